// [verilog/datapath_regs.svh]
// timing counts and field positions for the datapath sequencer
`ifndef DATAPATH_REGS_SVH
`define DATAPATH_REGS_SVH
`define WORD_W 16
`define EA_LSB_W 8
`define CLK_PERIOD_NS 100
`define QUARTER_NS 25
`define QUARTER_CYC ((`QUARTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OPC_HI 15
`define OPC_LO 12
`define SHDIR_BIT 11
`define SHCNT_HI 3
`define SHCNT_LO 0
`define OPC_LDA 4'h1
`define OPC_LDX 4'h2
`define OPC_ADD 4'h3
`define OPC_SHIFT 4'h4
`define OPC_AND 4'h5
`define RESET_PC 16'h0000
`endif

// [verilog/datapath_pkg.sv]
// types shared by the datapath sequencer
package datapath_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic [1:0] {
    sh_pass = 2'h0,
    sh_left = 2'h1,
    sh_right = 2'h2
  } shift_mode_e;
endpackage

// [verilog/adder_shift.sv]
// combinational adder followed by one-position shift control
`timescale 1ns/10ps
module adder_shift
  import datapath_pkg::*;
(
  // adder inputs
  input wire datapath_pkg::word_t source_bus,
  input wire datapath_pkg::word_t operand_bus,
  input wire logic carry_in,
  // shift selection
  input wire datapath_pkg::shift_mode_e shift_mode,
  // result
  output datapath_pkg::word_t result_bus
);
  import datapath_pkg::*;

  word_t sum; // adder output, carry out dropped

  // the adder is passive: it always sums its three inputs
  always_comb begin
    sum = source_bus + operand_bus + {15'h0000, carry_in};
  end

  // shift control moves the whole word one position at most
  always_comb begin
    case (shift_mode)
      sh_left: result_bus = {sum[14:0], 1'b0};
      sh_right: result_bus = {1'b0, sum[15:1]};
      default: result_bus = sum;
    endcase
  end
endmodule

// [verilog/cpu_datapath_sequencer.sv]
// sequencer for fetch, load, add, shift and and on a 16-bit datapath
`timescale 1ns/10ps
`include "datapath_regs.svh"
module cpu_datapath_sequencer
  import datapath_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // memory side
  output datapath_pkg::word_t mem_addr,
  output logic mem_read,
  input wire logic mem_done,
  input wire datapath_pkg::word_t memory_read_bus,
  // visible state
  output datapath_pkg::word_t acc,
  output datapath_pkg::word_t index_reg,
  output datapath_pkg::word_t pc,
  output datapath_pkg::word_t instr,
  output logic busy
);
  import datapath_pkg::*;

  typedef enum logic [6:0] {
    st_fetch_addr = 7'h01,
    st_fetch_read = 7'h02,
    st_decode = 7'h04,
    st_op_read = 7'h08,
    st_op_load = 7'h10,
    st_execute = 7'h20,
    st_shift = 7'h40
  } state_e;

  state_e state, next_state;
  word_t read_latch, next_read_latch; // memory read-data latch
  word_t operand, next_operand; // operand register
  word_t next_acc, next_index_reg, next_pc, next_instr, next_mem_addr;
  logic next_mem_read;
  logic [3:0] shift_left_cnt, next_shift_left_cnt; // passes still to do
  logic [1:0] stretch, next_stretch; // sub-pass counter inside a stretched cycle
  logic inc_done, next_inc_done; // counter increment already made this fetch
  logic next_busy; // busy as it will stand after the coming edge

  // bus drivers
  logic drv_pc, drv_acc, drv_idx, drv_opnd, cin;
  word_t source_bus, operand_bus, result_bus;
  shift_mode_e shift_mode;
  logic [3:0] opc;

  // each driver contributes ones when idle, so the bus ands its drivers
  function automatic word_t wired_and(input logic en, input word_t v);
    wired_and = en ? v : 16'hffff;
  endfunction

  assign opc = instr[`OPC_HI:`OPC_LO];

  // datapath gating; with nothing enabled the source bus reads all zero
  always_comb begin
    drv_pc = 1'b0;
    drv_acc = 1'b0;
    drv_idx = 1'b0;
    drv_opnd = 1'b0;
    cin = 1'b0;
    shift_mode = sh_pass;
    case (state)
      st_fetch_addr: drv_pc = 1'b1;
      st_fetch_read: begin
        drv_pc = 1'b1;
        cin = !inc_done;
      end
      st_op_load: drv_opnd = 1'b1;
      st_execute: begin
        if (opc == `OPC_ADD) begin
          drv_acc = 1'b1;
          drv_opnd = 1'b1;
        end else if (opc == `OPC_AND) begin
          drv_acc = 1'b1;
          drv_idx = 1'b1;
        end else begin
          drv_opnd = 1'b1;
        end
      end
      st_shift: begin
        drv_acc = 1'b1;
        if (stretch == 2'h0) begin
          shift_mode = instr[`SHDIR_BIT] ? sh_right : sh_left;
        end
      end
      default: ;
    endcase
  end

  // source and operand buses; a zero from any driver wins its bit, so two
  // registers gated together leave their bitwise and on the source bus
  always_comb begin
    if (drv_pc | drv_acc | drv_idx) begin
      source_bus = wired_and(drv_pc, pc) & wired_and(drv_acc, acc)
        & wired_and(drv_idx, index_reg);
    end else begin
      source_bus = 16'h0000;
    end
    operand_bus = drv_opnd ? operand : 16'h0000;
  end

  // adder and shift control, shared by every transfer except memory captures and the operand address
  adder_shift adder_shift_inst (
    .source_bus(source_bus),
    .operand_bus(operand_bus),
    .carry_in(cin),
    .shift_mode(shift_mode),
    .result_bus(result_bus)
  );

  // sequencer next-state and register transfers
  always_comb begin
    next_state = state;
    next_read_latch = read_latch;
    next_operand = operand;
    next_acc = acc;
    next_index_reg = index_reg;
    next_pc = pc;
    next_instr = instr;
    next_mem_addr = mem_addr;
    next_mem_read = 1'b0;
    next_shift_left_cnt = shift_left_cnt;
    next_stretch = stretch;
    next_inc_done = inc_done;
    case (state)
      st_fetch_addr: begin
        next_mem_addr = result_bus;
        next_mem_read = 1'b1;
        next_inc_done = 1'b0;
        next_state = st_fetch_read;
      end
      st_fetch_read: begin
        next_mem_read = !mem_done;
        if (!inc_done) begin
          next_pc = result_bus;
          next_inc_done = 1'b1;
        end
        if (mem_done) begin
          next_read_latch = memory_read_bus;
          next_instr = memory_read_bus;
          next_state = st_decode;
        end
      end
      st_decode: begin
        case (opc)
          `OPC_LDA, `OPC_LDX, `OPC_ADD: begin
            next_mem_addr = {8'h00, instr[`EA_LSB_W-1:0]};
            next_mem_read = 1'b1;
            next_state = st_op_read;
          end
          `OPC_AND: next_state = st_execute;
          `OPC_SHIFT: begin
            next_shift_left_cnt = instr[`SHCNT_HI:`SHCNT_LO];
            next_stretch = 2'h0;
            next_state = (instr[`SHCNT_HI:`SHCNT_LO] == 4'h0) ? st_fetch_addr : st_shift;
          end
          default: next_state = st_fetch_addr;
        endcase
      end
      st_op_read: begin
        next_mem_read = !mem_done;
        if (mem_done) begin
          next_read_latch = memory_read_bus;
          next_operand = memory_read_bus;
          next_state = (opc == `OPC_ADD) ? st_execute : st_op_load;
        end
      end
      st_op_load: begin
        if (opc == `OPC_LDX) next_index_reg = result_bus;
        else next_acc = result_bus;
        next_state = st_fetch_addr;
      end
      st_execute: begin
        next_acc = result_bus;
        next_state = st_fetch_addr;
      end
      st_shift: begin
        // first pass takes one step, later ones wait a one-cycle stretch first (the quarter cycle rounded up)
        if (stretch == 2'h0) begin
          next_acc = result_bus;
          next_shift_left_cnt = shift_left_cnt - 4'h1;
          next_stretch = 2'(`QUARTER_CYC);
          if (shift_left_cnt == 4'h1) next_state = st_fetch_addr;
        end else begin
          next_stretch = stretch - 2'h1;
        end
      end
      default: next_state = st_fetch_addr;
    endcase
    // busy drops as the sequencer heads back to fetch the next word
    next_busy = (next_state != st_fetch_addr);
  end

  // state registers only; every transfer is decided above
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= st_fetch_addr;
      read_latch <= 16'h0000;
      operand <= 16'h0000;
      acc <= 16'h0000;
      index_reg <= 16'h0000;
      pc <= `RESET_PC;
      instr <= 16'h0000;
      mem_addr <= 16'h0000;
      mem_read <= 1'b0;
      shift_left_cnt <= 4'h0;
      stretch <= 2'h0;
      inc_done <= 1'b0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      read_latch <= next_read_latch;
      operand <= next_operand;
      acc <= next_acc;
      index_reg <= next_index_reg;
      pc <= next_pc;
      instr <= next_instr;
      mem_addr <= next_mem_addr;
      mem_read <= next_mem_read;
      shift_left_cnt <= next_shift_left_cnt;
      stretch <= next_stretch;
      inc_done <= next_inc_done;
      busy <= next_busy;
    end
  end

  // checks
  fetch_inc_a: assert property (@(posedge clk) disable iff (reset)
    state == st_fetch_read && !inc_done |=> pc == $past(pc) + 16'h0001)
    else $error("pc not incremented during fetch");
  fetch_addr_a: assert property (@(posedge clk) disable iff (reset)
    state == st_fetch_addr |=> mem_addr == $past(pc) && mem_read)
    else $error("fetch address not loaded from pc");
  instr_load_a: assert property (@(posedge clk) disable iff (reset)
    state == st_fetch_read && mem_done |=> instr == $past(memory_read_bus))
    else $error("instruction not captured");
  opnd_load_a: assert property (@(posedge clk) disable iff (reset)
    state == st_op_read && mem_done |=> operand == $past(memory_read_bus))
    else $error("operand not captured");
  ea_low_a: assert property (@(posedge clk) disable iff (reset)
    state == st_op_read |-> mem_addr == {8'h00, instr[7:0]})
    else $error("effective address wrong");
  add_sum_a: assert property (@(posedge clk) disable iff (reset)
    state == st_execute && opc == `OPC_ADD |=> acc == $past(acc) + $past(operand))
    else $error("add result wrong");
  and_prod_a: assert property (@(posedge clk) disable iff (reset)
    state == st_execute && opc == `OPC_AND |=> acc == ($past(acc) & $past(index_reg)))
    else $error("and result wrong");
  shift_left_a: assert property (@(posedge clk) disable iff (reset)
    state == st_shift && stretch == 2'h0 && !instr[11] |=> acc == {$past(acc[14:0]), 1'b0})
    else $error("left shift wrong");
  shift_end_a: assert property (@(posedge clk) disable iff (reset)
    state == st_shift && stretch == 2'h0 && shift_left_cnt == 4'h1 |=> state == st_fetch_addr)
    else $error("shift did not terminate");
  idle_zero_a: assert property (@(posedge clk) disable iff (reset)
    state == st_decode |-> operand_bus == 16'h0000 && !cin)
    else $error("idle adder inputs not zero");
  fetch_c: cover property (@(posedge clk) state == st_fetch_read && mem_done);
  add_c: cover property (@(posedge clk) state == st_execute && opc == `OPC_ADD);
  shift_c: cover property (@(posedge clk) state == st_shift && stretch != 2'h0);
  load_c: cover property (@(posedge clk) state == st_op_load && opc == `OPC_LDX);
  // load targets, right shift, stretch spacing and address hold; a read
  // whose address moved under it would fetch the wrong word silently
  load_acc_a: assert property (@(posedge clk) disable iff (reset)
    state == st_op_load && opc == `OPC_LDA |=> acc == $past(operand))
    else $error("accumulator load wrong");
  load_index_a: assert property (@(posedge clk) disable iff (reset)
    state == st_op_load && opc == `OPC_LDX |=> index_reg == $past(operand))
    else $error("index load wrong");
  shift_right_a: assert property (@(posedge clk) disable iff (reset)
    state == st_shift && stretch == 2'h0 && instr[`SHDIR_BIT]
      |=> acc == {1'b0, $past(acc[15:1])})
    else $error("right shift wrong");
  shift_stretch_a: assert property (@(posedge clk) disable iff (reset)
    state == st_shift && stretch == 2'h0 && shift_left_cnt != 4'h1
      |=> state == st_shift && stretch != 2'h0)
    else $error("shift pass not stretched");
  addr_hold_a: assert property (@(posedge clk) disable iff (reset)
    mem_read && !mem_done |=> $stable(mem_addr))
    else $error("address moved during read");
endmodule

// [verification/mem_model.sv]
// behavioural main memory answering the sequencer's read requests
`timescale 1ns/10ps
module mem_model
  import datapath_pkg::*;
(
  // clock
  input wire logic clk,
  // request side
  input wire datapath_pkg::word_t mem_addr,
  input wire logic mem_read,
  input wire logic [3:0] wait_cycles,
  // answer side
  output logic mem_done,
  output datapath_pkg::word_t memory_read_bus
);
  word_t mem [0:255]; // small store, only low page is backed
  logic served; // one answer per request
  logic [3:0] cnt; // cycles waited so far
  initial begin
    mem_done = 1'b0;
    memory_read_bus = 16'h0000;
    served = 1'b0;
    cnt = 4'h0;
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  // answer once per request; outside the done cycle the bus shows junk
  always @(posedge clk) begin
    // a dropped request forgets its answer and any wait already counted
    if (!mem_read) begin
      served <= 1'b0;
      cnt <= 4'h0;
    end
    if (mem_done) begin
      mem_done <= #1 1'b0;
      memory_read_bus <= #1 ~memory_read_bus; // never leave the word standing
    end else if (mem_read && !served) begin
      if (cnt == wait_cycles) begin
        mem_done <= #1 1'b1;
        // unbacked addresses read junk, so a wide address shows up
        memory_read_bus <= #1 (mem_addr[15:8] == 8'h00) ? mem[mem_addr[7:0]] : 16'hdead;
        served <= 1'b1;
        cnt <= 4'h0;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

// [verification/test_cpu_datapath_sequencer.sv]
// self-checking bench for the datapath sequencer against a memory model
`timescale 1ns/10ps
module test_cpu_datapath_sequencer;
  import datapath_pkg::*;
  logic clk; // 10 MHz
  logic reset;
  logic [3:0] wait_cycles; // memory answer delay
  word_t mem_addr, memory_read_bus, acc, index_reg, pc, instr;
  logic mem_read, mem_done, busy;
  int n_fail = 0;
  int n_checks = 0;
  int t3, t1, n;

  cpu_datapath_sequencer cpu_datapath_sequencer_inst (.clk(clk), .reset(reset),
    .mem_addr(mem_addr), .mem_read(mem_read), .mem_done(mem_done),
    .memory_read_bus(memory_read_bus), .acc(acc), .index_reg(index_reg), .pc(pc),
    .instr(instr), .busy(busy));
  mem_model mem_model_inst (.clk(clk), .mem_addr(mem_addr), .mem_read(mem_read),
    .wait_cycles(wait_cycles), .mem_done(mem_done), .memory_read_bus(memory_read_bus));

  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // compare and count
  task automatic check(input word_t seen, input word_t exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // step until the counter shows p; the fetch address must be p-1
  task automatic run_to(input word_t p, output int c);
    c = 0;
    while (pc !== p && c < 400) begin
      @(posedge clk);
      #1;
      c++;
    end
    check(pc, p, "counter stuck");
    check(mem_addr, p - 16'h0001, "fetch address");
    check(word_t'(busy), 16'h0001, "busy in fetch");
  endtask

  task automatic do_reset(input logic [3:0] w);
    reset = 1'b1;
    wait_cycles = w;
    repeat (12) @(posedge clk);
    #1 reset = 1'b0;
  endtask

  // program: loads, add, and, shifts, a no-op, then a data word run as code
  task automatic t_program();
    #1;
    mem_model_inst.mem[0] = 16'h1f20; // load acc, junk in bits 11:8
    mem_model_inst.mem[1] = 16'h2021; // load index
    mem_model_inst.mem[2] = 16'h3022; // add
    mem_model_inst.mem[3] = 16'h5000; // and
    mem_model_inst.mem[4] = 16'h4003; // left by 3
    mem_model_inst.mem[5] = 16'h4801; // right by 1
    mem_model_inst.mem[6] = 16'h4000; // count 0
    mem_model_inst.mem[7] = 16'hf0f0; // plain data word
    mem_model_inst.mem[8'h20] = 16'h1234;
    mem_model_inst.mem[8'h21] = 16'h0ff0;
    mem_model_inst.mem[8'h22] = 16'h0101;
  endtask

  task automatic t_fetch_load(input logic [3:0] w);
    do_reset(w);
    run_to(16'h0002, n);
    check(acc, 16'h1234, "load acc");
    check(instr, 16'h1f20, "instruction register");
    run_to(16'h0003, n);
    check(index_reg, 16'h0ff0, "load index");
    $display("test fetch_load wait %0d done", w);
  endtask

  task automatic t_alu();
    run_to(16'h0004, n);
    check(acc, 16'h1335, "add");
    run_to(16'h0005, n);
    check(acc, 16'h0330, "and");
    $display("test alu done");
  endtask

  // a shift of 3 spends 4 more cycles than a shift of 1
  task automatic t_shift();
    run_to(16'h0006, t3);
    check(acc, 16'h1980, "left 3");
    run_to(16'h0007, t1);
    check(acc, 16'h0cc0, "right 1");
    check(word_t'(t3 - t1), 16'h0004, "stretch");
    run_to(16'h0008, n);
    check(acc, 16'h0cc0, "count 0");
    run_to(16'h0009, n);
    check(acc, 16'h0cc0, "data as code");
    $display("test shift done");
  endtask

  // main sequence
  initial begin
    reset = 1'b1;
    wait_cycles = 4'h0;
    t_program();
    t_fetch_load(4'h0);
    t_alu();
    t_shift();
    t_fetch_load(4'h5);
    wrap_up();
  end

  // watchdog: the run needs about 110 cycles, allow 2000
  initial begin
    #200000;
    n_fail++;
    wrap_up();
  end
endmodule
